/* File: logic/sensor_serial_port.sv */
// Two-wire half-duplex serial port with watchdog and power-down.
//
// Summary of operation
// RULE1 - Host clocks and starts; device never initiates.
// RULE2 - Data line changes only after falling edge.
// RULE3 - Two bytes MSB first: direction, address, data.
// RULE4 - Top bit one means write; host drives data.
// RULE5 - Device samples address and write data rising.
// RULE6 - Top bit zero means read; device drives data.
// RULE7 - Host floats line after last address bit.
// RULE8 - Device drives after falling edge past address.
// RULE9 - Device releases at rising edge after data.
// RULE10 - Device drives only during read data byte.
// RULE11 - Host should keep line driven when idle.
// RULE12 - Host toggles clock, waits timeout to resync.
// RULE13 - Timeout resets port, keeps register contents.
// RULE14 - Setting bit six enters power-down.
// RULE15 - Clearing bit six leaves power-down.
// RULE16 - Power-down disables watchdog, access still works.
// RULE17 - Host waits about 3 ms after wake.
// RULE18 - Host may verify writes by reading back.
// RULE19 - Host may check sync via identification read.
// RULE20 - Power-down acted on within one frame.
// RULE21 - Watchdog restarts on clock edges, 1.7 ms.
// RULE22 - Host idles serial clock high.
module sensor_serial_port
  import sensor_serial_pkg::*;
#(
  parameter int WD_TIMEOUT_CYCLES = WD_CYCLES
) (
  // Core clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Serial link
  input  wire logic sclk,
  input  wire logic sdioIn,
  output logic      sdioOut,
  output logic      sdioOeN,
  // Power management
  output logic      powerDown
);

  // ---------------------------------------------------------------
  // Link-side and core-side state
  // ---------------------------------------------------------------
  typedef struct packed {
    phase_e            phase;
    logic [3:0]        bitCount;
    logic [ADDR_W-1:0] shift;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] readData;
    logic              oeRise;
  } ser_s;

  typedef struct packed {
    logic oeFall;
    logic dataOut;
  } drv_s;

  typedef struct packed {
    logic prevSclk;
    logic powerDown;
  } core_s;

  ser_s  ser;
  ser_s  next_ser;
  drv_s  drv;
  drv_s  next_drv;
  core_s core;
  core_s next_core;

  logic [DATA_W-1:0] regFile [2**ADDR_W];
  logic              pdCtrl;
  logic              wrEn;
  logic [DATA_W-1:0] wrData;
  logic              wdFire;
  logic              serRst;
  logic [1:0]        syncIn;
  logic              sclkSync;
  logic              pdSync;
  logic              sclkEdge;

  // The serial engine is cleared by system reset or watchdog expiry.
  // The expiry pulse arrives only after a long clock stall, so its
  // release cannot race a link edge when the host honours the wait.
  assign serRst = sys_rst | wdFire;                              // [RULE13]

  // ---------------------------------------------------------------
  // Receive and sequence on rising serial clock
  // ---------------------------------------------------------------
  always_comb begin
    next_ser          = ser;
    next_ser.bitCount = ser.bitCount + BIT_STEP;
    wrEn              = 1'b0;
    wrData            = {ser.shift, sdioIn};
    case (ser.phase)
      PH_ADDR: begin
        next_ser.shift = {ser.shift[ADDR_W-2:0], sdioIn};        // [RULE5]
        if (ser.bitCount == LAST_ADDR_BIT) begin
          next_ser.addr = {ser.shift[ADDR_W-2:0], sdioIn};       // [RULE3]
          if (ser.shift[ADDR_W-1] == DIR_WRITE) begin
            next_ser.phase = PH_WRITE;                           // [RULE4]
          end else begin
            next_ser.phase    = PH_READ;                         // [RULE6]
            next_ser.readData = regFile[{ser.shift[ADDR_W-2:0],
                                         sdioIn}];
          end
        end
      end
      PH_WRITE: begin
        next_ser.shift = {ser.shift[ADDR_W-2:0], sdioIn};        // [RULE5]
        if (ser.bitCount == LAST_DATA_BIT) begin
          wrEn           = 1'b1;                                 // [RULE4]
          next_ser.phase = PH_ADDR;
        end
      end
      PH_READ: begin
        if (ser.bitCount == LAST_DATA_BIT) begin
          next_ser.oeRise = ~ser.oeRise;                         // [RULE9]
          next_ser.phase  = PH_ADDR;
        end
      end
      default: begin
        next_ser.phase = PH_ADDR;
      end
    endcase
  end

  // Nothing moves without a host clock edge or a serRst clear.
  always_ff @(posedge sclk or posedge serRst) begin              // [RULE1]
    if (serRst) begin
      ser <= '0;
    end else begin
      ser <= next_ser;
    end
  end

  // ---------------------------------------------------------------
  // Register file and power-down control
  // ---------------------------------------------------------------
  // Contents have no reset, so a watchdog expiry leaves them intact.
  always_ff @(posedge sclk) begin
    if (wrEn) begin
      regFile[ser.addr] <= wrData;                               // [RULE13]
    end
  end

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      pdCtrl <= PD_RESET;
    end else if (wrEn && ser.addr == OP_CTRL_ADDR) begin
      pdCtrl <= wrData[PD_BIT];                           // [RULE14] [RULE15]
    end
  end

  // ---------------------------------------------------------------
  // Drive on falling serial clock
  // ---------------------------------------------------------------
  always_comb begin
    next_drv = drv;
    if (ser.phase == PH_READ) begin
      if (ser.bitCount == FIRST_DATA_BIT) begin
        next_drv.oeFall = ~drv.oeFall;                           // [RULE8]
      end
      next_drv.dataOut = ser.readData[3'(LAST_DATA_BIT - ser.bitCount)];
    end
  end

  always_ff @(negedge sclk or posedge serRst) begin              // [RULE2]
    if (serRst) begin
      drv <= '0;
    end else begin
      drv <= next_drv;
    end
  end

  // The enable is a toggle pair: set on a falling edge, cleared on a
  // rising edge, so each edge owns exactly one flip-flop.
  assign sdioOeN = ~(drv.oeFall ^ ser.oeRise);                   // [RULE10]
  assign sdioOut = drv.dataOut;

  // ---------------------------------------------------------------
  // Core side: clock activity, watchdog and power-down
  // ---------------------------------------------------------------
  level_sync #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .clk    (clk),
    .rst    (sys_rst),
    .async  ({sclk, pdCtrl}),
    .synced (syncIn)
  );

  assign sclkSync = syncIn[1];
  assign pdSync   = syncIn[0];
  assign sclkEdge = sclkSync ^ core.prevSclk;                    // [RULE21]

  serial_watchdog #(
    .TIMEOUT_CYCLES (WD_TIMEOUT_CYCLES)
  ) u_watchdog (
    .clk     (clk),
    .rst     (sys_rst),
    .enable  (~core.powerDown),                                  // [RULE16]
    .restart (sclkEdge),                                         // [RULE21]
    .expire  (wdFire)
  );

  always_comb begin
    next_core           = core;
    next_core.prevSclk  = sclkSync;
    next_core.powerDown = pdSync;                                // [RULE20]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  assign powerDown = core.powerDown;

endmodule // sensor_serial_port

/* File: logic/sensor_serial_pkg.sv */
// Shared constants and types of the two-wire sensor serial port.
package sensor_serial_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  // Least watchdog timeout, rounded up to whole core cycles.
  localparam int WD_TIMEOUT_NS  = 1700000;
  localparam int WD_CYCLES      = (WD_TIMEOUT_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  // Longest delay from the power-down write to acting on it.
  localparam int FRAME_TIME_NS  = 333000;
  localparam int PD_MAX_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES    = 2;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int       ADDR_W         = 7;
  localparam int       DATA_W         = 8;
  localparam logic     DIR_WRITE      = 1'b1;
  localparam logic [3:0] LAST_ADDR_BIT  = 4'h7;
  localparam logic [3:0] FIRST_DATA_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT  = 4'hF;
  localparam logic [3:0] BIT_STEP       = 4'h1;

  // ---------------------------------------------------------------
  // Operating control register
  // ---------------------------------------------------------------
  localparam logic [6:0] OP_CTRL_ADDR = 7'h0A;
  localparam int         PD_BIT       = 6;
  localparam logic       PD_RESET     = 1'b0;

  typedef enum logic [1:0] {
    PH_ADDR  = 2'b00,
    PH_WRITE = 2'b01,
    PH_READ  = 2'b10
  } phase_e;

endpackage

/* File: logic/level_sync.sv */
// Two-stage synchroniser for a group of level signals.
module level_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [STAGES-1:0][WIDTH-1:0] chain;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], async};
    end
  end

  assign synced = chain[STAGES-1];

endmodule // level_sync

/* File: logic/serial_watchdog.sv */
// Inactivity counter that fires once when the serial clock stalls.
module serial_watchdog #(
  parameter int TIMEOUT_CYCLES = 17000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  input  wire logic restart,
  // Expiry
  output logic      expire
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);
  localparam logic [CW-1:0] DONE = CW'(TIMEOUT_CYCLES);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          fire;
  } wd_s;

  wd_s wd;
  wd_s next_wd;

  always_comb begin
    next_wd      = wd;
    next_wd.fire = 1'b0;
    if (!enable || restart) begin
      next_wd.count = '0;
    end else if (wd.count == LAST) begin
      // Saturate so an idle line gives one pulse, not a train.
      next_wd.count = DONE;
      next_wd.fire  = 1'b1;
    end else if (wd.count != DONE) begin
      next_wd.count = wd.count + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd <= '0;
    end else begin
      wd <= next_wd;
    end
  end

  assign expire = wd.fire;

endmodule // serial_watchdog

/* File: tb/sensor_serial_port_assertions.sv */
// Concurrent checks on the ports of the sensor serial port.
module sensor_serial_port_assertions
  import sensor_serial_pkg::*;
#(
  parameter int WD_TIMEOUT_CYCLES = 50
) (
  // Core side
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic powerDown,
  // Link side
  input wire logic sclk,
  input wire logic sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  bitCnt;
  logic [14:0] sh;
  logic [1:0]  negCnt;
  logic        dirBit;
  logic        pdWant;
  logic        sclkQ;
  int          idle;
  wire         stall = idle == WD_TIMEOUT_CYCLES && !powerDown;
  wire         resync = sys_rst || stall;

  // The bit mirror is cleared on a clock stall, as the port itself is.
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) begin
      sclkQ <= 1'b1;
      idle  <= 0;
    end else begin
      sclkQ <= sclk;
      // The port's own counter is held clear while powered down.
      idle  <= (sclk != sclkQ || powerDown) ? 0
             : idle + int'(idle <= WD_TIMEOUT_CYCLES);
    end

  always_ff @(posedge sclk or posedge resync)
    if (resync) begin
      bitCnt <= 4'h0;
      dirBit <= 1'b1;
    end else begin
      bitCnt <= bitCnt + 4'h1;
      sh     <= {sh[13:0], sdioIn};
      if (bitCnt == 4'h0) dirBit <= sdioIn;
    end

  always_ff @(posedge sclk or posedge sys_rst)
    if (sys_rst) pdWant <= PD_RESET;
    else if (bitCnt == 4'hF && sh[14] && sh[13:7] == OP_CTRL_ADDR)
      pdWant <= sh[PD_BIT-1];

  // Two falling edges may share one core cycle, hence a counter.
  always_ff @(negedge sclk or posedge sys_rst)
    if (sys_rst) negCnt <= 2'h0;
    else negCnt <= negCnt + 2'h1;

  addr_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    bitCnt < 4'h8 |-> sdioOeN) else $error("line driven in first byte");
  write_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    dirBit && bitCnt > 4'h7 |-> sdioOeN) else $error("line driven on write");
  read_drive_a: assert property (@(posedge sclk) disable iff (sys_rst)
    !dirBit && bitCnt > 4'h7 |-> !sdioOeN) else $error("read data undriven");
  release_end_a: assert property (@(posedge sclk) disable iff (sys_rst)
    $rose(sdioOeN) |-> bitCnt == 4'h0) else $error("release off frame end");
  out_steady_a: assert property (@(posedge clk) disable iff (sys_rst)
    !sdioOeN && $changed(sdioOut) |-> $changed(negCnt))
    else $error("data changed off falling edge");
  pd_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    powerDown != pdWant |-> ##[1:8] powerDown == pdWant)
    else $error("power-down not applied");
  pd_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(powerDown) |-> powerDown == pdWant) else $error("stray power-down");
  reset_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> sdioOeN && !powerDown) else $error("bad reset state");
endmodule // sensor_serial_port_assertions

bind sensor_serial_port sensor_serial_port_assertions #(
  .WD_TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES)
) u_chk (
  .clk(clk), .sys_rst(sys_rst), .powerDown(powerDown), .sclk(sclk),
  .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOeN(sdioOeN)
);

/* File: tb/host_model.sv */
// Host controller model that clocks and frames the two-wire link.
module host_model (
  // Core clock, used only for the floating pattern
  input  wire logic clk,
  // Link
  input  wire logic sdioOut,
  input  wire logic sdioOeN,
  output logic      sclk,
  output logic      sdioIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hostOe   = 1'b1;
  logic hostBit  = 1'b1;
  logic floatBit = 1'b0;

  // An undriven wire toggles so that no stale level can pass as data.
  always @(posedge clk) floatBit <= ~floatBit;
  assign sdioIn = !sdioOeN ? sdioOut : hostOe ? hostBit : floatBit;
  initial sclk = 1'b1;

  task automatic bitCycle(input logic b, input logic nxt, output logic s);
    sclk = 1'b0;
    #10 hostBit = b;
    #30 s = sdioIn;
    sclk = 1'b1;
    #20 hostOe = nxt;
    #20;
  endtask

  // Sends the first n bits of v, most significant first.
  task automatic frame(input logic [15:0] v, input int n,
                       output logic [7:0] rd);
    logic s;
    for (int i = 0; i < n; i++) begin
      bitCycle(v[15-i], v[15] || i < 7 || i == 15, s);
      if (i > 7) rd[15-i] = s;
    end
  endtask
endmodule // host_model

/* File: tb/sensor_two_wire_serial_port_test.sv */
// Self-checking bench of the sensor serial port.
module sensor_two_wire_serial_port_test import sensor_serial_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WD = 50;
  logic       clk    = 1'b0;
  logic       sysRst = 1'b1;
  logic       sclk;
  logic       sdioIn;
  logic       sdioOut;
  logic       sdioOeN;
  logic       powerDown;
  logic [7:0] rd;
  int         failures    = 0;
  int         totalChecks = 0;
  int         cycles      = 0;
  // Frame then expected read byte; writes are checked by the reads after.
  logic [23:0] rows [6] = '{24'h95A500, 24'h1500A5, 24'hFF0100,
                            24'h7F0001, 24'h808000, 24'h000080};

  sensor_serial_port #(.WD_TIMEOUT_CYCLES(WD)) u_dut (
    .clk(clk), .sys_rst(sysRst), .sclk(sclk), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOeN(sdioOeN), .powerDown(powerDown));
  host_model host (.clk(clk), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
    .sclk(sclk), .sdioIn(sdioIn));

  always #50 clk = ~clk;

  task automatic test_done();
    $display("checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    check("idle enable", 8'h01, {7'h00, sdioOeN});
    foreach (rows[i]) begin
      host.frame(rows[i][23:8], 16, rd);
      if (!rows[i][23]) check("read data", rows[i][7:0], rd);
    end
    // A torn frame is dropped once the clock stalls past the timeout.
    host.frame(16'hAB00, 5, rd);
    repeat (2 * WD) @(posedge clk);
    host.frame(16'h1500, 16, rd);
    check("resync read", 8'hA5, rd);
    host.frame({DIR_WRITE, OP_CTRL_ADDR, 8'h40}, 16, rd);
    repeat (10) @(posedge clk);
    check("power down", 8'h01, {7'h00, powerDown});
    // With the watchdog off, a stalled frame must resume intact.
    host.frame({DIR_WRITE, 7'h20, 8'h00}, 8, rd);
    repeat (2 * WD) @(posedge clk);
    host.frame(16'h5A00, 8, rd);
    host.frame({1'b0, OP_CTRL_ADDR, 8'h00}, 16, rd);
    check("control read", 8'h40, rd);
    host.frame({DIR_WRITE, OP_CTRL_ADDR, 8'h00}, 16, rd);
    repeat (10) @(posedge clk);
    check("wake", 8'h00, {7'h00, powerDown});
    repeat (30000) @(posedge clk);
    host.frame(16'h2000, 16, rd);
    check("stalled write", 8'h5A, rd);
    test_done();
  end
endmodule // sensor_two_wire_serial_port_test
